/* rsq_cfg.svh */
/*
 * Constants of the reset sequencer register block: offsets, field
 * positions, reset values and sequencing counts.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define RSQ_N            10
`define RSQ_AW           5
`define RSQ_IDX_LAST     4'h9
`define RSQ_IDX_FIRST    4'h0
`define RSQ_IDX_ONE      4'h1
`define RSQ_CNT_ZERO     10'h000
`define RSQ_CNT_ONE      10'h001

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RSQ_OFF_LOG      5'h00
`define RSQ_OFF_IE       5'h04
`define RSQ_OFF_CTRL     5'h08
`define RSQ_OFF_ASTEP    5'h0C
`define RSQ_OFF_DSTEP    5'h10
`define RSQ_OFF_DIRECT   5'h14
`define RSQ_OFF_MASK     5'h18

// ----------------------------------------------------------------------
// Event log fields
// ----------------------------------------------------------------------
`define RSQ_LOG_POR      0
`define RSQ_LOG_SWTRIG   1
`define RSQ_LOG_SRC_LO   2
`define RSQ_LOG_SRC_HI   11
`define RSQ_LOG_QUAL_LO  16
`define RSQ_LOG_QUAL_HI  25
`define RSQ_LOG_DWAIT    29
`define RSQ_LOG_AWAIT    30
`define RSQ_LOG_ACTIVE   31
`define RSQ_LOG_W1C      32'h63FF_0FFF
`define RSQ_LOG_RST      32'h0000_0001

// ----------------------------------------------------------------------
// Control and other fields
// ----------------------------------------------------------------------
`define RSQ_CTRL_INIT    1
`define RSQ_CTRL_SWDSRT  2
`define RSQ_CTRL_SWASRT  3
`define RSQ_DIR_VAL_LO   0
`define RSQ_DIR_VAL_HI   9
`define RSQ_DIR_TRG_LO   16
`define RSQ_DIR_TRG_HI   25
`define RSQ_STEP_RST     10'h3FF
`define RSQ_VEC_ZERO     10'h000
`define RSQ_WORD_ZERO    32'h0000_0000

// ----------------------------------------------------------------------
// Sequencing counts in clock cycles
// ----------------------------------------------------------------------
`define RSQ_ASRT_DLY     10'h004
`define RSQ_DSRT_DLY     10'h004
`define RSQ_MIN_HOLD     10'h008

`endif

/* rsq_pkg.sv */
/*
 * Types of the reset sequencer register block.
 * Assumes rsq_cfg.svh is reachable on the include path.
 */
`include "rsq_cfg.svh"

package rsq_pkg;

    typedef enum logic [2:0] {
        RSQ_IDLE,
        RSQ_ASRT,
        RSQ_AWAIT,
        RSQ_HOLD,
        RSQ_DSRT,
        RSQ_DWAIT
    } rsq_state_t;

    typedef struct packed {
        logic [2*`RSQ_N-1:0] s1;
        logic [2*`RSQ_N-1:0] s2;
    } rsq_sync_t;

    typedef struct packed {
        rsq_state_t        st;
        logic [3:0]        idx;
        logic [9:0]        cnt;
        logic [31:0]       log;
        logic [31:0]       ie;
        logic              sw_asrt;
        logic              sw_dsrt;
        logic [`RSQ_N-1:0] astep;
        logic [`RSQ_N-1:0] dstep;
        logic [`RSQ_N-1:0] mask;
        logic [`RSQ_N-1:0] outs;
        logic [`RSQ_N-1:0] src_prev;
        logic [`RSQ_N-1:0] qual_prev;
        logic [31:0]       rdata;
        logic              irq;
    } rsq_regs_t;

endpackage

/* rsq_sync.sv */
/*
 * Two-stage synchroniser for the reset source and qualifier pins.
 * Assumes pins are asynchronous levels; the first stage feeds only
 * the second.
 */
`timescale 1ns/1ps
`include "rsq_cfg.svh"

module rsq_sync
    import rsq_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic [2*`RSQ_N-1:0]  pin_i,
    output logic      [2*`RSQ_N-1:0]  sync_o
);

    rsq_sync_t r_q;
    rsq_sync_t r_d;

    always_comb begin
        r_d    = r_q;
        r_d.s1 = pin_i;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign sync_o = r_q.s2;

endmodule

/* rsq_csr.sv */
/*
 * Reset sequencer with its control and status registers: event log,
 * interrupt enables, software stepping, direct drive and masking of
 * ten sequenced reset outputs.
 * Assumes a single-cycle memory-mapped slave port driven by a host on
 * clk_i, and reset sources and qualifiers that arrive asynchronously.
 */
`timescale 1ns/1ps
`include "rsq_cfg.svh"

module rsq_csr
    import rsq_pkg::*;
#(
    parameter bit USE_QUAL = 1'b0
) (
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic [`RSQ_AW-1:0]   csr_addr_i,
    input  wire logic                 csr_write_i,
    input  wire logic                 csr_read_i,
    input  wire logic [31:0]          csr_wdata_i,
    output logic      [31:0]          csr_rdata_o,
    input  wire logic [`RSQ_N-1:0]    reset_source_input_i,
    input  wire logic [`RSQ_N-1:0]    deassert_qual_i,
    output logic      [`RSQ_N-1:0]    sequenced_output_o,
    output logic                      irq_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [`RSQ_AW-1:0] a,
                                 input logic [`RSQ_AW-1:0] off);
        hit = (a == off);
    endfunction

    rsq_regs_t            r_q;
    rsq_regs_t            r_d;
    logic [2*`RSQ_N-1:0]  pins_s;
    logic [`RSQ_N-1:0]    src_s;
    logic [`RSQ_N-1:0]    qual_s;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    rsq_sync u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .pin_i  ({deassert_qual_i, reset_source_input_i}),
        .sync_o (pins_s)
    );

    assign src_s  = pins_s[`RSQ_N-1:0];
    assign qual_s = pins_s[2*`RSQ_N-1:`RSQ_N];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [`RSQ_N-1:0] src_rise;
        logic [`RSQ_N-1:0] qual_rise;
        logic [31:0]       log_set;
        logic [31:0]       log_clr;
        logic              wr_log;
        logic              sw_init;
        logic              step_done;
        logic              dsrt_ready;
        logic [31:0]       rd;

        r_d        = r_q;
        src_rise   = src_s & ~r_q.src_prev;
        qual_rise  = qual_s & ~r_q.qual_prev;
        log_set    = `RSQ_WORD_ZERO;
        log_clr    = `RSQ_WORD_ZERO;
        wr_log     = csr_write_i && hit(csr_addr_i, `RSQ_OFF_LOG);
        sw_init    = 1'b0;
        step_done  = 1'b0;
        dsrt_ready = 1'b0;
        rd         = `RSQ_WORD_ZERO;

        r_d.src_prev  = src_s;
        r_d.qual_prev = qual_s;

        log_set[`RSQ_LOG_QUAL_HI:`RSQ_LOG_QUAL_LO] = qual_rise;

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (csr_write_i) begin
            if (hit(csr_addr_i, `RSQ_OFF_IE)) begin
                r_d.ie = csr_wdata_i & `RSQ_LOG_W1C;
            end
            if (hit(csr_addr_i, `RSQ_OFF_CTRL)) begin
                r_d.sw_dsrt = csr_wdata_i[`RSQ_CTRL_SWDSRT];
                r_d.sw_asrt = csr_wdata_i[`RSQ_CTRL_SWASRT];
                sw_init     = csr_wdata_i[`RSQ_CTRL_INIT];
            end
            if (hit(csr_addr_i, `RSQ_OFF_ASTEP)) begin
                r_d.astep = csr_wdata_i[`RSQ_N-1:0];
            end
            if (hit(csr_addr_i, `RSQ_OFF_DSTEP)) begin
                r_d.dstep = csr_wdata_i[`RSQ_N-1:0];
            end
            if (hit(csr_addr_i, `RSQ_OFF_MASK)) begin
                r_d.mask = csr_wdata_i[`RSQ_N-1:0];
            end
        end

        if (wr_log) begin
            log_clr = csr_wdata_i & `RSQ_LOG_W1C;
        end

        // --------------------------------------------------------------
        // Sequencer
        // --------------------------------------------------------------
        unique case (r_q.st)
            RSQ_IDLE: begin
                // Start requests while busy are dropped on purpose
                if ((|src_rise) || sw_init) begin
                    log_set[`RSQ_LOG_SRC_HI:`RSQ_LOG_SRC_LO] = src_rise;
                    log_set[`RSQ_LOG_SWTRIG] = sw_init;
                    r_d.st  = RSQ_ASRT;
                    r_d.idx = `RSQ_IDX_FIRST;
                    r_d.cnt = `RSQ_CNT_ZERO;
                end
            end
            RSQ_ASRT: begin
                if (!r_q.sw_asrt && r_q.cnt < `RSQ_ASRT_DLY) begin
                    r_d.cnt = r_q.cnt + `RSQ_CNT_ONE;
                end else begin
                    if (!r_q.mask[r_q.idx]) begin
                        r_d.outs[r_q.idx] = 1'b1;
                    end
                    if (r_q.sw_asrt && r_q.astep[r_q.idx]) begin
                        log_set[`RSQ_LOG_AWAIT] = 1'b1;
                        r_d.st = RSQ_AWAIT;
                    end else begin
                        step_done = 1'b1;
                    end
                end
            end
            RSQ_AWAIT: begin
                if (!r_q.log[`RSQ_LOG_AWAIT]) begin
                    step_done = 1'b1;
                end
            end
            RSQ_HOLD: begin
                if (r_q.cnt < `RSQ_MIN_HOLD) begin
                    r_d.cnt = r_q.cnt + `RSQ_CNT_ONE;
                end else if (!(|src_s)) begin
                    r_d.st  = RSQ_DSRT;
                    r_d.idx = `RSQ_IDX_FIRST;
                    r_d.cnt = `RSQ_CNT_ZERO;
                end
            end
            RSQ_DSRT: begin
                if (r_q.sw_dsrt) begin
                    dsrt_ready = 1'b1;
                end else if (USE_QUAL) begin
                    dsrt_ready = qual_s[r_q.idx];
                end else if (r_q.cnt < `RSQ_DSRT_DLY) begin
                    r_d.cnt = r_q.cnt + `RSQ_CNT_ONE;
                end else begin
                    dsrt_ready = 1'b1;
                end
                if (dsrt_ready) begin
                    r_d.outs[r_q.idx] = 1'b0;
                    if (r_q.sw_dsrt && r_q.dstep[r_q.idx]) begin
                        log_set[`RSQ_LOG_DWAIT] = 1'b1;
                        r_d.st = RSQ_DWAIT;
                    end else begin
                        step_done = 1'b1;
                    end
                end
            end
            RSQ_DWAIT: begin
                if (!r_q.log[`RSQ_LOG_DWAIT]) begin
                    step_done = 1'b1;
                end
            end
        endcase

        // Advance to the next output or the next phase
        if (step_done) begin
            r_d.cnt = `RSQ_CNT_ZERO;
            if (r_q.idx != `RSQ_IDX_LAST) begin
                r_d.idx = r_q.idx + `RSQ_IDX_ONE;
                r_d.st  = (r_q.st == RSQ_ASRT || r_q.st == RSQ_AWAIT)
                          ? RSQ_ASRT : RSQ_DSRT;
            end else begin
                r_d.idx = `RSQ_IDX_FIRST;
                r_d.st  = (r_q.st == RSQ_ASRT || r_q.st == RSQ_AWAIT)
                          ? RSQ_HOLD : RSQ_IDLE;
            end
        end

        if (csr_write_i && hit(csr_addr_i, `RSQ_OFF_DIRECT)) begin
            for (int i = 0; i < `RSQ_N; i++) begin
                // value applies only with its trigger
                if (csr_wdata_i[`RSQ_DIR_TRG_LO + i]) begin
                    r_d.outs[i] = csr_wdata_i[`RSQ_DIR_VAL_LO + i];
                end
            end
        end
        // mask writes never touch outs here

        // Set wins over a same-cycle clear
        r_d.log = (r_q.log & ~log_clr) | log_set;
        r_d.log[`RSQ_LOG_ACTIVE] = (r_d.st != RSQ_IDLE);

        r_d.irq = |(r_d.log & r_d.ie & `RSQ_LOG_W1C);

        // --------------------------------------------------------------
        // Read data, registered one cycle after the read strobe
        // --------------------------------------------------------------
        if (csr_read_i) begin
            if (hit(csr_addr_i, `RSQ_OFF_LOG)) begin
                rd = r_q.log;
            end else if (hit(csr_addr_i, `RSQ_OFF_IE)) begin
                rd = r_q.ie;
            end else if (hit(csr_addr_i, `RSQ_OFF_CTRL)) begin
                rd[`RSQ_CTRL_SWDSRT] = r_q.sw_dsrt;
                rd[`RSQ_CTRL_SWASRT] = r_q.sw_asrt;
            end else if (hit(csr_addr_i, `RSQ_OFF_ASTEP)) begin
                rd[`RSQ_N-1:0] = r_q.astep;
            end else if (hit(csr_addr_i, `RSQ_OFF_DSTEP)) begin
                rd[`RSQ_N-1:0] = r_q.dstep;
            end else if (hit(csr_addr_i, `RSQ_OFF_MASK)) begin
                rd[`RSQ_N-1:0] = r_q.mask;
            end
            r_d.rdata = rd;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_q.st        <= RSQ_IDLE;
            r_q.idx       <= `RSQ_IDX_FIRST;
            r_q.cnt       <= `RSQ_CNT_ZERO;
            r_q.log       <= `RSQ_LOG_RST;
            r_q.ie        <= `RSQ_WORD_ZERO;
            r_q.sw_asrt   <= 1'b0;
            r_q.sw_dsrt   <= 1'b0;
            r_q.astep     <= `RSQ_STEP_RST;
            r_q.dstep     <= `RSQ_STEP_RST;
            r_q.mask      <= `RSQ_VEC_ZERO;
            r_q.outs      <= `RSQ_VEC_ZERO;
            r_q.src_prev  <= `RSQ_VEC_ZERO;
            r_q.qual_prev <= `RSQ_VEC_ZERO;
            r_q.rdata     <= `RSQ_WORD_ZERO;
            r_q.irq       <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign csr_rdata_o        = r_q.rdata;
    assign sequenced_output_o = r_q.outs;
    assign irq_o              = r_q.irq;

endmodule

/* rsq_csr_assertions.sv */
/* Port checker for the reset sequencer register block.
   Assumes it is bound into rsq_csr and that the host only starts a
   sequence while the block is idle. */
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module rsq_csr_assertions #(
    parameter bit USE_QUAL = 1'b0
) (
    input logic               clk_i,
    input logic               nrst_i,
    input logic [`RSQ_AW-1:0] csr_addr_i,
    input logic               csr_write_i,
    input logic               csr_read_i,
    input logic [31:0]        csr_wdata_i,
    input logic [31:0]        csr_rdata_o,
    input logic [`RSQ_N-1:0]  reset_source_input_i,
    input logic [`RSQ_N-1:0]  deassert_qual_i,
    input logic [`RSQ_N-1:0]  sequenced_output_o,
    input logic               irq_o
);
    // ----------------------------------------
    // Shadows of written registers
    // ----------------------------------------
    logic [31:0] ie_q;
    logic [3:0]  ctl_q;
    logic [9:0]  ast_q;
    logic [9:0]  dst_q;
    logic [9:0]  msk_q;
    logic        dir_w;
    assign dir_w = csr_write_i && csr_addr_i == `RSQ_OFF_DIRECT;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ie_q  <= '0;
            ctl_q <= '0;
            ast_q <= `RSQ_STEP_RST;
            dst_q <= `RSQ_STEP_RST;
            msk_q <= '0;
        end else if (csr_write_i) begin
            case (csr_addr_i)
                `RSQ_OFF_IE:    ie_q  <= csr_wdata_i;
                `RSQ_OFF_CTRL:  ctl_q <= csr_wdata_i[3:0];
                `RSQ_OFF_ASTEP: ast_q <= csr_wdata_i[9:0];
                `RSQ_OFF_DSTEP: dst_q <= csr_wdata_i[9:0];
                `RSQ_OFF_MASK:  msk_q <= csr_wdata_i[9:0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_init;
        csr_write_i && csr_addr_i == `RSQ_OFF_CTRL && csr_wdata_i[1];
    endsequence
    sequence s_rd_log;
        csr_read_i && csr_addr_i == `RSQ_OFF_LOG && !csr_write_i;
    endsequence
    // Pause must outlast the host's reaction time
    sequence s_paused;
        $stable(sequenced_output_o)[*8];
    endsequence
    a_reset_vals: assert property (
        $rose(nrst_i) |-> csr_rdata_o == 32'h0
        && sequenced_output_o == 10'h000 && !irq_o)
        else $error("outputs not idle after reset");
    a_ctrl_reads0: assert property (
        csr_read_i && csr_addr_i == `RSQ_OFF_CTRL |=> !csr_rdata_o[1])
        else $error("initiate bit read back as one");
    a_init_logs: assert property (
        s_init ##[1:2] s_rd_log |=> csr_rdata_o[31] && csr_rdata_o[1])
        else $error("started sequence not shown in log");
    a_direct_drive: assert property (
        dir_w |=> ((sequenced_output_o ^ $past(csr_wdata_i[9:0]))
        & $past(csr_wdata_i[25:16])) == 10'h000)
        else $error("direct drive not applied");
    a_irq_level: assert property (
        s_rd_log ##1 ((csr_rdata_o & ie_q & `RSQ_LOG_W1C) != 0)
        |-> ##[0:1] irq_o)
        else $error("enabled event without interrupt");
    a_irq_off: assert property (
        csr_write_i && csr_addr_i == `RSQ_OFF_IE && csr_wdata_i == 32'h0
        |-> ##2 !irq_o)
        else $error("interrupt with all enables off");
    a_astep_hold: assert property (
        ctl_q[3] && !$past(dir_w) && |(sequenced_output_o
        & ~$past(sequenced_output_o) & ast_q) |=> s_paused)
        else $error("assert step did not pause");
    a_dstep_hold: assert property (
        ctl_q[2] && !$past(dir_w) && |(~sequenced_output_o
        & $past(sequenced_output_o) & dst_q) |=> s_paused)
        else $error("deassert step did not pause");
    a_mask_blocks: assert property (
        !$past(dir_w) |-> (sequenced_output_o & ~$past(sequenced_output_o)
        & $past(msk_q)) == 10'h000)
        else $error("masked output asserted");
    a_mask_no_drop: assert property (
        csr_write_i && csr_addr_i == `RSQ_OFF_MASK
        |=> ($past(sequenced_output_o) & ~sequenced_output_o) == 10'h000)
        else $error("mask write released an output");
endmodule
bind rsq_csr rsq_csr_assertions #(.USE_QUAL(USE_QUAL)) i_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .csr_addr_i(csr_addr_i),
    .csr_write_i(csr_write_i), .csr_read_i(csr_read_i),
    .csr_wdata_i(csr_wdata_i), .csr_rdata_o(csr_rdata_o),
    .reset_source_input_i(reset_source_input_i),
    .deassert_qual_i(deassert_qual_i),
    .sequenced_output_o(sequenced_output_o), .irq_o(irq_o));

/* rsq_far.sv */
/* Far-side model: the reset source and qualifier pins.
   Assumes the bench raises requests; pins follow them as levels. */
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module rsq_far (
    input  logic              clk_i,
    input  logic [`RSQ_N-1:0] src_req_i,
    input  logic [`RSQ_N-1:0] qual_req_i,
    output logic [`RSQ_N-1:0] src_o,
    output logic [`RSQ_N-1:0] qual_o
);
    logic [`RSQ_N-1:0] src_q;
    logic [`RSQ_N-1:0] qual_q;
    initial begin
        src_o = '0;
        qual_o = '0;
    end
    // Taken on rise, moved on fall: no race with the bench
    always @(posedge clk_i) begin
        src_q  <= src_req_i;
        qual_q <= qual_req_i;
    end
    always @(negedge clk_i) begin
        src_o  <= src_q;
        qual_o <= qual_q;
    end
endmodule

/* test_rsq_csr.sv */
/* Self-checking bench of the reset sequencer register block.
   Assumes rsq_csr, rsq_far and the bound checker are compiled. */
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module test_rsq_csr;
    logic               clk_i;
    logic               nrst_i;
    logic               wr_s;
    logic               rd_s;
    logic               irq_o;
    logic [`RSQ_AW-1:0] adr;
    logic [31:0]        wd;
    logic [31:0]        rdo;
    logic [31:0]        d;
    logic [9:0]         src;
    logic [9:0]         qual;
    logic [9:0]         src_req;
    logic [9:0]         qual_req;
    logic [9:0]         outs;
    logic [9:0]         outs_q;
    logic [31:0]        rdo_q;
    logic [9:0]         e;
    logic [31:0]        rv [8] = '{32'h1, 32'h0, 32'h0, 32'h3FF,
                                   32'h3FF, 32'h0, 32'h0, 32'h0};
    int                 n_mismatch;
    int                 compares;
    rsq_csr i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .csr_addr_i(adr),
        .csr_write_i(wr_s), .csr_read_i(rd_s), .csr_wdata_i(wd),
        .csr_rdata_o(rdo), .reset_source_input_i(src),
        .deassert_qual_i(qual), .sequenced_output_o(outs), .irq_o(irq_o));
    // Qualifier-paced copy on the same bus and pins
    rsq_csr #(.USE_QUAL(1'b1)) i_dut_qual (.clk_i(clk_i), .nrst_i(nrst_i),
        .csr_addr_i(adr), .csr_write_i(wr_s), .csr_read_i(rd_s),
        .csr_wdata_i(wd), .csr_rdata_o(rdo_q),
        .reset_source_input_i(src), .deassert_qual_i(qual),
        .sequenced_output_o(outs_q), .irq_o());
    rsq_far i_far (.clk_i(clk_i), .src_req_i(src_req),
        .qual_req_i(qual_req), .src_o(src), .qual_o(qual));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, s, x);
        end
    endtask
    task automatic ck1(input logic s, input logic x);
        check({31'h0, s}, {31'h0, x});
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(negedge clk_i);
        adr = a;
        wd = v;
        wr_s = 1'b1;
        @(negedge clk_i);
        wr_s = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(negedge clk_i);
        adr = a;
        rd_s = 1'b1;
        @(negedge clk_i);
        rd_s = 1'b0;
        d = rdo;
    endtask
    task automatic wait_out(input logic [9:0] x);
        for (int k = 0; k < 100 && outs !== x; k++) @(negedge clk_i);
        check({22'h0, outs}, {22'h0, x});
    endtask
    // Polls the live active bit; leaves the last log value in d
    task automatic wait_idle;
        d = 32'h8000_0000;
        for (int k = 0; k < 200 && d[31]; k++) rd(`RSQ_OFF_LOG);
        ck1(d[31], 1'b0);
    endtask
    task automatic src_pulse(input logic [9:0] v);
        src_req = v;
        repeat (6) @(negedge clk_i);
        src_req = '0;
        wait_idle;
    endtask
    task automatic finish_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        {nrst_i, wr_s, rd_s, adr, wd, src_req, qual_req} = '0;
        n_mismatch = 0;
        compares = 0;
        repeat (10) @(negedge clk_i);
        nrst_i = 1'b1;
        // Reset values, write-only and unmapped places read zero
        for (int i = 0; i < 8; i++) begin
            rd(5'(4 * i));
            check(d, rv[i]);
        end
        wr(`RSQ_OFF_IE, 32'hFFFF_FFFF);
        rd(`RSQ_OFF_IE);
        check(d, `RSQ_LOG_W1C);
        ck1(irq_o, 1'b1);
        wr(`RSQ_OFF_LOG, 32'h0);
        rd(`RSQ_OFF_LOG);
        check(d, 32'h1);
        wr(`RSQ_OFF_LOG, 32'h1);
        rd(`RSQ_OFF_LOG);
        check(d, 32'h0);
        ck1(irq_o, 1'b0);
        wr(`RSQ_OFF_IE, 32'h0);
        wr(`RSQ_OFF_MASK, 32'h200);
        rd(`RSQ_OFF_LOG);
        ck1(d[31], 1'b0);
        wr(`RSQ_OFF_CTRL, 32'h2);
        rd(`RSQ_OFF_LOG);
        check(d & 32'h8000_0002, 32'h8000_0002);
        rd(`RSQ_OFF_CTRL);
        check(d, 32'h0);
        wait_out(10'h1FF);
        wait_idle;
        wait_out(10'h000);
        wr(`RSQ_OFF_LOG, 32'hFFFF_FFFF);
        wr(`RSQ_OFF_MASK, 32'h0);
        wr(`RSQ_OFF_IE, 32'h0000_0FFC);
        for (int i = 0; i < 10; i++) begin
            src_pulse(10'(1 << i));
            check(d, 32'h1 << (2 + i));
            ck1(irq_o, 1'b1);
            wr(`RSQ_OFF_LOG, 32'hFFFF_FFFF);
            @(negedge clk_i);
            ck1(irq_o, 1'b0);
        end
        // Only even qualifiers are enabled
        wr(`RSQ_OFF_IE, 32'h0155_0000);
        for (int i = 0; i < 10; i++) begin
            qual_req = 10'(1 << i);
            repeat (6) @(negedge clk_i);
            qual_req = '0;
            rd(`RSQ_OFF_LOG);
            check(d, 32'h1 << (16 + i));
            ck1(irq_o, i % 2 == 0);
            // Copy left waiting in its deassert phase steps per qualifier
            e = 10'h1FF & ~10'((2 << i) - 1);
            check({22'h0, outs_q}, {22'h0, e});
            ck1(rdo_q[31], i != 9);
            wr(`RSQ_OFF_LOG, d);
        end
        wr(`RSQ_OFF_IE, 32'h6000_0000);
        ck1(d[31], 1'b0);
        wr(`RSQ_OFF_CTRL, 32'hE);
        rd(`RSQ_OFF_CTRL);
        check(d, 32'hC);
        for (int k = 0; k < 20; k++) begin
            e = k < 10 ? 10'((2 << k) - 1) : ~10'((2 << (k - 10)) - 1);
            wait_out(e);
            rd(`RSQ_OFF_LOG);
            check(d & 32'h6000_0000, k < 10 ? 32'h4000_0000
                                            : 32'h2000_0000);
            ck1(irq_o, 1'b1);
            repeat (10) @(negedge clk_i);
            wait_out(e);
            wr(`RSQ_OFF_LOG, d & 32'h6000_0000);
        end
        wait_idle;
        wr(`RSQ_OFF_CTRL, 32'h0);
        wr(`RSQ_OFF_IE, 32'h0);
        wr(`RSQ_OFF_LOG, 32'hFFFF_FFFF);
        wr(`RSQ_OFF_DIRECT, 32'h0000_03FF);
        wait_out(10'h000);
        wr(`RSQ_OFF_DIRECT, 32'h000F_0005);
        wait_out(10'h005);
        wr(`RSQ_OFF_MASK, 32'h5);
        wait_out(10'h005);
        wr(`RSQ_OFF_DIRECT, 32'h03FF_0000);
        wait_out(10'h000);
        wr(`RSQ_OFF_MASK, 32'h0);
        // Own reset after a finished run leaves only the power-on flag
        src_pulse(10'h001);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        rd(`RSQ_OFF_LOG);
        check(d, 32'h1);
        finish_test;
    end
endmodule
